// File: logic/mid_core.sv
// Instruction decode and execute core for the 13-bit word microcontroller
//
// Overview of operation
// - Fetch one 13-bit word: opcode plus operands.
// - Cycle is 2 periods, or 4 if option.
// - Writes to program counter take two cycles.
// - Jumps, calls, returns, taken skips take two.
// - Timer tick is Fosc/4 in four-period mode.
// - Set, clear, test any register bit.
// - I/O registers act as general registers.
// - Register field selects any register.
// - Literals 8 bits; jump targets 10 plus page.
// - Decrement-skip writes back, skips zero, no flags.
// - Increment-to-acc-skip: A gets R+1, no flags.
// - I/O control writes only 5-6 and B-F; reads of other indices still load A.
// - Config word bit 10 picks the period.
`timescale 1ns/100ps
module mid_core import mid_pkg::*; #(
  parameter int STACK_D = MID_STACK_D
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration word (static strap, from same domain)
  input wire logic [12:0] cfg_word,
  // Program memory
  output logic [11:0] prog_addr,
  input wire logic [12:0] prog_data,
  // Control register port
  output logic io_we,
  output logic [3:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  output logic io_bad_access,
  // Core status
  output logic [7:0] acc,
  output logic timer_tick,
  output logic instr_done,
  output logic int_en,
  output logic sleep_req,
  output logic wdt_clear
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  initial begin
    if (STACK_D < 1 || STACK_D > 8) $error("mid_core: STACK_D 1..8");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Valid control register index for the I/O transfer pair
  function automatic logic io_ok(input logic [3:0] a);
    return (a == 4'h5) || (a == 4'h6) || (a >= 4'hB);
  endfunction

  // 8-bit add with carry in: {half carry, carry, sum}; carry sits in bit 8
  // so the rotate and decimal adjust paths can share the same flag slot
  function automatic logic [9:0] add8(input logic [7:0] x,
                                      input logic [7:0] y,
                                      input logic ci);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
    return {lo[4], hi[4], hi[3:0], lo[3:0]};
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [1:0] ph_q, ph_d;          // Oscillator period within a cycle
  logic [11:0] pc_q, pc_d;         // Program counter
  logic [7:0] acc_q, acc_d;        // Accumulator
  logic [7:0] st_q, st_d;          // Status register
  mid_phase_t mode_q, mode_d;      // Execute or flush
  logic ie_q, ie_d;                // Interrupt enable
  logic [11:0] stk_q [STACK_D];    // Return stack
  logic [11:0] stk_d [STACK_D];
  logic [2:0] sp_q, sp_d;          // Stack pointer
  logic tick_q, tick_d;            // Timer tick
  logic done_q, done_d;            // Instruction finished
  logic slp_q, slp_d;              // Sleep request pulse
  logic wdc_q, wdc_d;              // Watchdog clear pulse
  logic bad_q, bad_d;              // Bad control access flag
  logic iow_q, iow_d;              // Control register write strobe
  logic [3:0] ioa_q, ioa_d;        // Control register address
  logic [7:0] iod_q, iod_d;        // Control register data

  mid_rf_if rf ();

  mid_regfile #(.DEPTH(64)) u_rf (
    .clk(clk),
    .sys_rst(sys_rst),
    .rf(rf)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [12:0] iw;         // Current word
  mid_op_t op;             // Operation class
  logic [5:0] ra;          // Register field
  logic [2:0] bsel;        // Bit field
  logic [7:0] rv;          // Register value (PC and status muxed in)
  logic last_ph;           // Last period of the cycle

  assign iw = prog_data;
  assign ra = iw[5:0];
  assign bsel = iw[8:6];
  assign rf.raddr = ra;

  // Registers are all one space, I/O ones included, so any op uses them
  always_comb begin
    if (ra == MID_ADDR_PC) begin
      rv = pc_q[7:0];
    end else if (ra == MID_ADDR_ST) begin
      rv = st_q;
    end else begin
      rv = rf.rdata;
    end
  end

  // Opcode classifier
  always_comb begin
    op = OP_BAD;
    if (iw[12]) begin
      if (!iw[11]) begin
        op = iw[10] ? OP_JMP : OP_CALL;
      end else if (iw[10:8] == 3'h4) begin
        op = OP_RETURN_WITH_LITERAL;
      end else if (iw[10:8] == 3'h6) begin
        op = (iw[7:0] == 8'h01) ? OP_INT : OP_BAD;
      end else begin
        op = OP_LIT;
      end
    end else if (iw[11]) begin
      case (iw[10:9])
        2'h0: op = OP_BIT_CLR;
        2'h1: op = OP_BIT_SET;
        2'h2: op = OP_SKIP_CLR;
        default: op = OP_SKIP_SET;
      endcase
    end else if (iw[11:6] != 6'h00) begin
      op = (iw[11:6] == 6'h02) ? OP_BAD : OP_ALU;
      if (iw[11:0] == 12'h080) op = OP_ALU;
    end else begin
      case (iw[5:0])
        6'h00: op = OP_NOP;
        6'h01: op = OP_DAA;
        6'h02: op = OP_CONTW;
        6'h03: op = OP_SLEEP;
        6'h04: op = OP_WDTC;
        6'h10: op = OP_ENI;
        6'h11: op = OP_DISI;
        6'h12: op = OP_RET;
        6'h13: op = OP_RETURN_FROM_INTERRUPT;
        6'h14: op = OP_CONTR;
        default: op = iw[4] ? OP_IOR : OP_IOW;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Execute: everything commits on the last period of a cycle
  // ----------------------------------------------------------------------
  logic [7:0] res;      // Result value
  logic to_acc;         // Result goes to accumulator
  logic wr_reg;         // Result goes to register
  logic fz, fc, fdc;    // Which flags update
  logic [2:0] nc;       // New C/DC/Z: {z, dc, c}
  logic skip;           // Skip next word
  logic jump;           // Program flow redirect
  logic [11:0] tgt;     // Redirect target
  logic [9:0] sum;      // Adder output
  logic cin;            // Carry in

  always_comb begin
    res = 8'h00;
    to_acc = 1'b0;
    wr_reg = 1'b0;
    fz = 1'b0;
    fc = 1'b0;
    fdc = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    tgt = pc_q + 12'h001;
    sum = 10'h000;
    cin = st_q[MID_ST_C];
    case (op)
      OP_ALU: begin
        case (iw[11:8])
          4'h0: begin
            // Move accumulator, or clear
            res = iw[7] ? 8'h00 : acc_q;
            to_acc = (iw[7:6] == 2'h2);
            wr_reg = !to_acc;
            fz = iw[7];
          end
          4'h1: begin
            if (!iw[7]) begin
              sum = add8(rv, ~acc_q, 1'b1);   // R - A
              fc = 1'b1;
              fdc = 1'b1;
            end else begin
              sum = add8(rv, 8'hFF, 1'b0);    // R - 1
            end
            res = sum[7:0];
            fz = 1'b1;
          end
          4'h2: begin
            res = iw[7] ? (acc_q & rv) : (acc_q | rv);
            fz = 1'b1;
          end
          4'h3: begin
            sum = add8(acc_q, rv, 1'b0);
            res = iw[7] ? sum[7:0] : (acc_q ^ rv);
            fz = 1'b1;
            fc = iw[7];
            fdc = iw[7];
          end
          4'h4: begin
            res = iw[7] ? ~rv : rv;
            fz = 1'b1;
          end
          4'h5: begin
            // Increment, or decrement with skip and no flags
            res = iw[7] ? rv - 8'h01 : rv + 8'h01;
            fz = !iw[7];
            skip = iw[7] && (res == 8'h00);
          end
          4'h6: begin
            res = iw[7] ? {rv[6:0], cin} : {cin, rv[7:1]};
            sum[8] = iw[7] ? rv[7] : rv[0];
            fc = 1'b1;
          end
          default: begin
            // Swap, or increment with skip and no flags
            res = iw[7] ? rv + 8'h01 : {rv[3:0], rv[7:4]};
            skip = iw[7] && (res == 8'h00);
          end
        endcase
        if (iw[11:8] != 4'h0) begin
          to_acc = !iw[6];     // Odd pair selects register target
          wr_reg = iw[6];
        end
      end
      OP_BIT_CLR: begin
        res = rv & ~(8'h01 << bsel);
        wr_reg = 1'b1;
      end
      OP_BIT_SET: begin
        res = rv | (8'h01 << bsel);
        wr_reg = 1'b1;
      end
      OP_SKIP_CLR: skip = !rv[bsel];
      OP_SKIP_SET: skip = rv[bsel];
      OP_LIT: begin
        case (iw[10:8])
          3'h0: res = iw[7:0];
          3'h1: res = acc_q | iw[7:0];
          3'h2: res = acc_q & iw[7:0];
          3'h3: res = acc_q ^ iw[7:0];
          3'h5: begin
            sum = add8(iw[7:0], ~acc_q, 1'b1);
            res = sum[7:0];
          end
          default: begin
            sum = add8(iw[7:0], acc_q, 1'b0);
            res = sum[7:0];
          end
        endcase
        to_acc = 1'b1;
        fz = (iw[10:8] != 3'h0);
        fc = iw[10:8] >= 3'h5;
        fdc = fc;
      end
      OP_DAA: begin
        res = acc_q;
        if (acc_q[3:0] > 4'h9 || st_q[MID_ST_DC]) res = res + 8'h06;
        if (res[7:4] > 4'h9 || cin) begin
          res = res + 8'h60;
          sum[8] = 1'b1;
        end
        to_acc = 1'b1;
        fc = 1'b1;
      end
      OP_CONTR, OP_IOR: begin
        res = io_rdata;
        to_acc = 1'b1;
      end
      OP_RETURN_WITH_LITERAL: begin
        res = iw[7:0];
        to_acc = 1'b1;
        jump = 1'b1;
        tgt = stk_q[sp_q];
      end
      OP_RET, OP_RETURN_FROM_INTERRUPT: begin
        jump = 1'b1;
        tgt = stk_q[sp_q];
      end
      OP_CALL, OP_JMP: begin
        jump = 1'b1;
        tgt = {st_q[MID_ST_PG0+1:MID_ST_PG0], iw[9:0]};
      end
      OP_INT: begin
        jump = 1'b1;
        tgt = MID_INT_VEC;
      end
      default: res = 8'h00;
    endcase
    // Carry from bit 8, half carry from bit 9
    nc = {res == 8'h00, sum[9], sum[8]};
    // Register write to the PC also redirects and costs a second cycle
    if (wr_reg && ra == MID_ADDR_PC) begin
      jump = 1'b1;
      tgt = {pc_q[11:8], res};
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------
  assign last_ph = (ph_q == (cfg_word[MID_CFG_CLK_BIT] ? MID_PER_LONG
                                                       : MID_PER_SHORT));

  always_comb begin
    ph_d = last_ph ? 2'h0 : ph_q + 2'h1;
    pc_d = pc_q;
    acc_d = acc_q;
    st_d = st_q;
    mode_d = mode_q;
    ie_d = ie_q;
    stk_d = stk_q;
    sp_d = sp_q;
    tick_d = last_ph;
    done_d = 1'b0;
    slp_d = 1'b0;
    wdc_d = 1'b0;
    bad_d = 1'b0;
    iow_d = 1'b0;
    ioa_d = ioa_q;
    iod_d = iod_q;
    rf.we = 1'b0;
    rf.waddr = ra;
    rf.wdata = res;
    if (last_ph) begin
      done_d = 1'b1;
      pc_d = pc_q + 12'h001;
      if (mode_q == MID_FLUSH) begin
        mode_d = MID_EXEC;                     // Second cycle is a dummy
        pc_d = pc_q;                           // Next address already set
      end else begin
        if (to_acc) acc_d = res;
        if (wr_reg && ra != MID_ADDR_PC && ra != MID_ADDR_ST) begin
          rf.we = 1'b1;
        end
        if (wr_reg && ra == MID_ADDR_ST) st_d = res;
        if (fc) st_d[MID_ST_C] = nc[0];
        if (fdc) st_d[MID_ST_DC] = nc[1];
        if (fz) st_d[MID_ST_Z] = nc[2];
        // A skip steps over one word; the dummy cycle then holds the PC
        if (skip) pc_d = pc_q + 12'h002;
        if (jump) pc_d = tgt;
        if (jump || skip) mode_d = MID_FLUSH;
        if (op == OP_CALL || op == OP_INT) begin
          sp_d = (sp_q == 3'(STACK_D - 1)) ? 3'h0 : sp_q + 3'h1;
          stk_d[sp_d] = pc_q + 12'h001;
        end
        if (op == OP_RET || op == OP_RETURN_FROM_INTERRUPT || op == OP_RETURN_WITH_LITERAL) begin
          sp_d = (sp_q == 3'h0) ? 3'(STACK_D - 1) : sp_q - 3'h1;
        end
        if (op == OP_ENI || op == OP_RETURN_FROM_INTERRUPT) ie_d = 1'b1;
        if (op == OP_DISI) ie_d = 1'b0;
        slp_d = (op == OP_SLEEP);
        wdc_d = (op == OP_SLEEP) || (op == OP_WDTC);
        if (op == OP_IOW || op == OP_IOR) begin
          // Only the documented control registers accept writes; a refused read still loads A
          bad_d = !io_ok(iw[3:0]);
          iow_d = (op == OP_IOW) && io_ok(iw[3:0]);
        end
        if (op == OP_CONTW) iow_d = 1'b1;
        ioa_d = (op == OP_CONTW) ? 4'h0 : iw[3:0];
        iod_d = acc_q;
      end
    end
  end

  // Register all sequencer state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_q <= 2'h0;
      pc_q <= MID_PC_RST;
      acc_q <= 8'h00;
      st_q <= 8'h00;
      mode_q <= MID_EXEC;
      ie_q <= 1'b0;
      for (int i = 0; i < STACK_D; i++) stk_q[i] <= 12'h000;
      sp_q <= 3'h0;
      tick_q <= 1'b0;
      done_q <= 1'b0;
      slp_q <= 1'b0;
      wdc_q <= 1'b0;
      bad_q <= 1'b0;
      iow_q <= 1'b0;
      ioa_q <= 4'h0;
      iod_q <= 8'h00;
    end else begin
      ph_q <= ph_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      st_q <= st_d;
      mode_q <= mode_d;
      ie_q <= ie_d;
      stk_q <= stk_d;
      sp_q <= sp_d;
      tick_q <= tick_d;
      done_q <= done_d;
      slp_q <= slp_d;
      wdc_q <= wdc_d;
      bad_q <= bad_d;
      iow_q <= iow_d;
      ioa_q <= ioa_d;
      iod_q <= iod_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prog_addr = pc_q;
  assign acc = acc_q;
  assign timer_tick = tick_q;
  assign instr_done = done_q;
  assign int_en = ie_q;
  assign sleep_req = slp_q;
  assign wdt_clear = wdc_q;
  assign io_bad_access = bad_q;
  assign io_we = iow_q;
  assign io_addr = ioa_q;
  assign io_wdata = iod_q;

endmodule

// File: logic/mid_pkg.sv
// Package of constants and types for the instruction decode/execute block
package mid_pkg;

  // ----------------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------------
  localparam int MID_IW = 13;          // Instruction word width
  localparam int MID_DW = 8;           // Data width
  localparam int MID_PW = 12;          // Program counter width
  localparam int MID_RAW = 6;          // Register field width
  localparam int MID_LIT8_W = 8;       // Short literal width
  localparam int MID_LIT10_W = 10;     // Jump/call literal width
  localparam int MID_CFG_CLK_BIT = 10; // Period option bit in config word

  // ----------------------------------------------------------------------
  // Register file addresses
  // ----------------------------------------------------------------------
  localparam logic [5:0] MID_ADDR_PC = 6'h02;  // Program counter register
  localparam logic [5:0] MID_ADDR_ST = 6'h03;  // Status register
  localparam logic [5:0] MID_ADDR_IF = 6'h0F;  // Interrupt flag register

  // Status bit positions
  localparam int MID_ST_C = 0;
  localparam int MID_ST_DC = 1;
  localparam int MID_ST_Z = 2;
  localparam int MID_ST_PG0 = 5;

  // ----------------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] MID_PER_SHORT = 2'h1;  // Two periods, last index
  localparam logic [1:0] MID_PER_LONG = 2'h3;   // Four periods, last index
  localparam logic [11:0] MID_PC_RST = 12'h3FF; // Reset vector
  localparam logic [11:0] MID_INT_VEC = 12'h001; // Software interrupt vector
  localparam int MID_STACK_D = 5;                // Stack depth

  // Execution phase: normal or dummy (flushed) cycle
  typedef enum logic {MID_EXEC, MID_FLUSH} mid_phase_t;

  // Decoded operation class
  typedef enum logic [4:0] {
    OP_NOP, OP_DAA, OP_CONTW, OP_SLEEP, OP_WDTC, OP_IOW, OP_ENI, OP_DISI,
    OP_RET, OP_RETURN_FROM_INTERRUPT, OP_CONTR, OP_IOR, OP_ALU, OP_BIT_CLR, OP_BIT_SET,
    OP_SKIP_CLR, OP_SKIP_SET, OP_CALL, OP_JMP, OP_LIT, OP_RETURN_WITH_LITERAL, OP_INT,
    OP_BAD
  } mid_op_t;

endpackage

// File: logic/mid_rf_if.sv
// Interface carrying register file access between core and register file
`timescale 1ns/100ps
interface mid_rf_if;
  logic [5:0] raddr;  // Read address
  logic [7:0] rdata;  // Read data
  logic we;           // Write strobe
  logic [5:0] waddr;  // Write address
  logic [7:0] wdata;  // Write data

  modport core (output raddr, we, waddr, wdata, input rdata);
  modport file (input raddr, we, waddr, wdata, output rdata);
endinterface

// File: logic/mid_regfile.sv
// General register file: 64 bytes of flip-flops with a combinational read
`timescale 1ns/100ps
module mid_regfile import mid_pkg::*; #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core access
  mid_rf_if.file rf
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] mem_q [DEPTH];  // Register contents
  logic [7:0] mem_d [DEPTH];  // Next contents

  initial begin
    if (DEPTH != 64) $error("mid_regfile: DEPTH must be 64");
  end

  // Read is combinational so the core sees it in the same cycle
  assign rf.rdata = mem_q[rf.raddr];

  // Next value: one write port
  always_comb begin
    mem_d = mem_q;
    if (rf.we) begin
      mem_d[rf.waddr] = rf.wdata;
    end
  end

  // Register the array; reset clears everything
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      mem_q <= mem_d;
    end
  end

endmodule

// File: tb/mid_prog_mem.sv
// Program memory model that feeds instruction words to the core
`timescale 1ns/100ps
module mid_prog_mem #(
  parameter logic [7:0] CTRL_RD = 8'h5A  // Control register read pattern
) (
  // Fetch side
  input wire logic [11:0] prog_addr,
  output logic [12:0] prog_data,
  // Control register read side
  output logic [7:0] io_rdata
);
  // ----------------------------------------------------------------------
  // Word store
  // ----------------------------------------------------------------------
  // Filled by the bench; its programs never set or clear interrupt flag
  // bits with the bit instructions
  logic [12:0] mem [0:4095];
  // Whole 13-bit word answered in the same cycle
  assign prog_data = mem[prog_addr];
  // Fixed pattern so a read through the port is easy to recognise
  assign io_rdata = CTRL_RD;
endmodule

// File: tb/mid_assertions.sv
// Concurrent checks on the ports of the decode/execute core
`timescale 1ns/100ps
module mid_assertions import mid_pkg::*; #(
  parameter int STACK_D = MID_STACK_D
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration and program memory
  input wire logic [12:0] cfg_word,
  input wire logic [11:0] prog_addr,
  input wire logic [12:0] prog_data,
  // Control register port
  input wire logic io_we,
  input wire logic [3:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_bad_access,
  // Core status
  input wire logic [7:0] acc,
  input wire logic timer_tick,
  input wire logic instr_done,
  input wire logic int_en,
  input wire logic sleep_req,
  input wire logic wdt_clear
);
  // ----------------------------------------------------------------------
  // Clocking and shared sequences
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Next pulse exactly two clocks after the last
  sequence s_gap2(logic s);
    !s ##1 s;
  endsequence
  // Next pulse exactly four clocks after the last
  sequence s_gap4(logic s);
    !s [*3] ##1 s;
  endsequence

  // Indices the control port accepts (0 is the option register)
  logic idx_ok;
  assign idx_ok = io_addr inside {4'h0, 4'h5, 4'h6, [4'hB:4'hF]};

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_done_short;
    instr_done && !cfg_word[10] |=> s_gap2(instr_done);
  endproperty
  a_done_short: assert property (p_done_short)
    else $error("instruction cycle not two clocks");
  property p_done_long;
    instr_done && cfg_word[10] |=> s_gap4(instr_done);
  endproperty
  a_done_long: assert property (p_done_long)
    else $error("instruction cycle not four clocks");
  property p_tick_short;
    timer_tick && !cfg_word[10] |=> s_gap2(timer_tick);
  endproperty
  a_tick_short: assert property (p_tick_short)
    else $error("timer tick not at half oscillator rate");
  property p_tick_long;
    timer_tick && cfg_word[10] |=> s_gap4(timer_tick);
  endproperty
  a_tick_long: assert property (p_tick_long)
    else $error("timer tick not at quarter oscillator rate");
  property p_pc_hold;
    !instr_done |-> $stable(prog_addr);
  endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("fetch address moved inside a cycle");
  property p_acc_hold;
    !instr_done |-> $stable(acc);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("accumulator moved inside a cycle");
  property p_io_write;
    io_we |-> instr_done && idx_ok && io_wdata == acc;
  endproperty
  a_io_write: assert property (p_io_write)
    else $error("control write with bad index or data");
  property p_io_bad;
    io_bad_access |-> instr_done && !io_we && !idx_ok;
  endproperty
  a_io_bad: assert property (p_io_bad)
    else $error("bad access flag on a valid index");
  property p_sleep_pulse;
    sleep_req |-> wdt_clear && instr_done;
  endproperty
  a_sleep_pulse: assert property (p_sleep_pulse)
    else $error("sleep request without watchdog clear");
  property p_ie_change;
    $changed(int_en) |-> instr_done;
  endproperty
  a_ie_change: assert property (p_ie_change)
    else $error("interrupt enable moved inside a cycle");
endmodule

bind mid_core mid_assertions #(.STACK_D(STACK_D)) u_mid_chk (
  .clk(clk), .sys_rst(sys_rst), .cfg_word(cfg_word),
  .prog_addr(prog_addr), .prog_data(prog_data), .io_we(io_we),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .io_bad_access(io_bad_access), .acc(acc), .timer_tick(timer_tick),
  .instr_done(instr_done), .int_en(int_en), .sleep_req(sleep_req),
  .wdt_clear(wdt_clear)
);

// File: tb/mcu_instruction_decode_execute_tb.sv
// Self-checking bench for the instruction decode/execute core
`timescale 1ns/100ps
module mcu_instruction_decode_execute_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [12:0] cfg_word = 13'h0080;  // Reserved bit 7 kept high
  logic [11:0] prog_addr;
  logic [12:0] prog_data;
  logic io_we;
  logic [3:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_bad_access;
  logic [7:0] acc;
  logic timer_tick;
  logic instr_done;
  logic int_en;
  int n_errors = 0;
  int num_checks = 0;

  always #2 clk = ~clk;  // 250 MHz

  mid_core DUT (
    .clk(clk), .sys_rst(sys_rst), .cfg_word(cfg_word),
    .prog_addr(prog_addr), .prog_data(prog_data), .io_we(io_we),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_bad_access(io_bad_access), .acc(acc), .timer_tick(timer_tick),
    .instr_done(instr_done), .int_en(int_en), .sleep_req(), .wdt_clear()
  );
  mid_prog_mem u_mem (
    .prog_addr(prog_addr), .prog_data(prog_data), .io_rdata(io_rdata)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  // Program image: unused words read as no-operation
  task automatic ld(input logic [11:0] a, input logic [12:0] w[$]);
    foreach (w[i]) u_mem.mem[a + 12'(i)] = w[i];
  endtask
  task automatic clr();
    foreach (u_mem.mem[i]) u_mem.mem[i] = 13'h0000;
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Reset, then count cycles and bad-index pulses up to the first write
  // on the control port, which every program uses as its end marker
  task automatic run(input logic m, input int ncyc, input int nbad,
                     input logic [7:0] wd);
    int n;
    int b;
    int k;
    n = 0;
    b = 0;
    @(posedge clk);
    sys_rst <= 1'b1;
    cfg_word <= m ? 13'h0480 : 13'h0080;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    for (k = 0; k < 400 && io_we !== 1'b1; k++) begin
      @(posedge clk);
      #1;
      if (instr_done === 1'b1) n++;
      if (io_bad_access === 1'b1) b++;
    end
    if (k == 400) begin
      n_errors++;
      $display("MISMATCH t=%0t no control write seen", $time);
      summarize();
    end else begin
      chkn(n, ncyc, "instruction cycles");
      chkn(b, nbad, "bad index pulses");
      chk8(io_wdata, wd, "written value");
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_basic(input logic m);
    clr();
    ld(12'h3FF, '{13'h18A5, 13'h0010, 13'h0003, 13'h0005});
    run(m, 4, 0, 8'hA5);
    chk8({7'h00, int_en}, 8'h01, "interrupt enable");
    $display("End of scenario basic, long mode %0b", m);
  endtask
  // Jump, bit set/clear, untaken and taken bit skips on a general register
  task automatic t_bits();
    clr();
    ld(12'h3FF, '{13'h1410});
    ld(12'h010, '{13'h180F, 13'h0060, 13'h0BE0, 13'h0820, 13'h0DE0,
                 13'h0FE0, 13'h18FF, 13'h0420, 13'h0006});
    run(1'b0, 11, 0, 8'h8E);
    $display("End of scenario bits");
  endtask
  // Decrement and increment skips; flags and source register checked
  task automatic t_skip();
    clr();
    ld(12'h3FF, '{13'h1801, 13'h0061, 13'h05E1, 13'h1833, 13'h18FF,
                 13'h0062, 13'h07A2, 13'h1844, 13'h0403, 13'h0322,
                 13'h0321, 13'h0005});
    run(1'b0, 12, 0, 8'hFF);
    $display("End of scenario skip");
  endtask
  // Program counter write, refused indices, call and literal return
  task automatic t_pcw();
    clr();
    ld(12'h3FF, '{13'h1810, 13'h0042});
    ld(12'h410, '{13'h0017, 13'h0063, 13'h0008, 13'h1020, 13'h0323,
                 13'h000B});
    ld(12'h020, '{13'h1C77});
    run(1'b1, 12, 2, 8'h2D);
    $display("End of scenario program counter write");
  endtask

  initial begin
    t_basic(1'b0);
    t_basic(1'b1);
    t_bits();
    t_skip();
    t_pcw();
    summarize();
  end
endmodule
